// *** verilog/span_cal_pkg.sv ***
// Purpose: Shared constants and types of the span calibration sequencer.
// Assumes: pclk at 200 MHz; all phase times counted in whole seconds ticks.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
`default_nettype none
package span_cal_pkg;
  // System clock rate and period.
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  // One seconds tick, in clock cycles.
  localparam int SEC_S = 1;
  localparam int SEC_TICK_CYCLES = CLK_HZ * SEC_S;
  // Phase times in seconds (range timeout kept in tenths of a minute, clearing timeout in minutes).
  localparam logic [8:0] MENU_HOLD_S = 9'h003;
  localparam logic [8:0] MENU_TIMEOUT_S = 9'h005;
  localparam int RANGE_TIMEOUT_MIN_X10 = 25;
  localparam logic [8:0] RANGE_TIMEOUT_S = 9'(RANGE_TIMEOUT_MIN_X10 * 60 / 10);
  localparam logic [8:0] ADJUST_S = 9'h03C;
  localparam logic [8:0] STAB_S = 9'h01E;
  localparam int CLEAR_TIMEOUT_MIN = 5;
  localparam logic [8:0] CLEAR_TIMEOUT_S = 9'(CLEAR_TIMEOUT_MIN * 60);
  localparam logic [8:0] MSG_S = 9'h002;
  // Sequence counts.
  localparam logic [1:0] MAX_EXTRA_CHECKS = 2'h3;
  localparam logic [1:0] REPORT_LAST = 2'h2;
  localparam logic [1:0] FAULT_RPT_LAST = 2'h1;
  // Reading limits in percent of range.
  localparam logic [7:0] FULL_SCALE_PCT = 8'h64;
  localparam logic [7:0] CLEAR_LIMIT_PCT = 8'h05;
  localparam logic [7:0] STAB_TOL_PCT = 8'h02;
  // Current loop levels in microamps.
  localparam logic [15:0] LOOP_MIN_UA = 16'h0FA0;
  localparam logic [15:0] LOOP_UA_PER_PCT = 16'h00A0;
  localparam logic [15:0] LOOP_CAL_UA = 16'h07D0;
  localparam logic [15:0] LOOP_FAULT_UA = 16'h0000;
  // Serial status bit positions.
  localparam int STS_RANGE_BIT = 1;
  localparam int STS_STAB_BIT = 2;
  localparam int STS_CLEAR_BIT = 3;
  localparam int STS_CAL_BIT = 14;
  // Register offsets and reset values.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LOOP = 8'h08;
  localparam logic [7:0] ADDR_DISPLAY = 8'h0C;
  localparam logic [7:0] SPAN_LEVEL_RST = 8'h32;
  localparam int CTRL_O2_BIT = 0;
  localparam int CTRL_SPAN_LSB = 8;
  // Display message codes.
  localparam logic [3:0] MSG_READING = 4'h0;
  localparam logic [3:0] MSG_CAL_MENU = 4'h1;
  localparam logic [3:0] MSG_APPLY_GAS = 4'h2;
  localparam logic [3:0] MSG_AS_FOUND = 4'h3;
  localparam logic [3:0] MSG_ADJUSTING = 4'h4;
  localparam logic [3:0] MSG_SPAN_OK = 4'h5;
  localparam logic [3:0] MSG_LIFE = 4'h6;
  localparam logic [3:0] MSG_REMOVE_GAS = 4'h7;
  localparam logic [3:0] MSG_SPAN_COMPLETE = 4'h8;
  localparam logic [3:0] MSG_RANGE_FAULT = 4'h9;
  localparam logic [3:0] MSG_STAB_FAULT = 4'hA;
  localparam logic [3:0] MSG_CLEAR_FAULT = 4'hB;
  localparam logic [3:0] MSG_FAULT_DETECTED = 4'hC;
  // Sequencer states, one-hot.
  typedef enum logic [8:0] {
    ST_NORMAL = 9'h001,
    ST_MENU = 9'h002,
    ST_APPLY = 9'h004,
    ST_ADJUST = 9'h008,
    ST_STABLE = 9'h010,
    ST_REPORT = 9'h020,
    ST_CLEAR = 9'h040,
    ST_DONE = 9'h080,
    ST_FAULT_RPT = 9'h100
  } seq_state_type;
endpackage
`default_nettype wire

// *** verilog/span_calibration_sequencer.sv ***
// Purpose: Span calibration sequencer with current loop, status and display drive.
// Assumes: sensor_reading and sensor_life_pct come from logic on pclk, in percent.
// Notes: Registers sit on APB with no wait states; magnet pins are synchronised.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module span_calibration_sequencer
  import span_cal_pkg::*;
#(
  parameter int TICK_CYCLES = SEC_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic left_magnet_switch,
  input wire logic right_magnet_switch,
  input wire logic [7:0] sensor_reading,
  input wire logic [7:0] sensor_life_pct,
  output logic [15:0] loop_current_ua,
  output logic [15:0] serial_status,
  output logic [3:0] display_msg,
  output logic [7:0] display_value,
  output logic display_flash
);

  // Whole state of the block in one record.
  typedef struct packed {
    seq_state_type state;        // Sequencer phase.
    logic [1:0] sync_l;          // Left magnet synchroniser.
    logic [1:0] sync_r;          // Right magnet synchroniser.
    logic [27:0] div;            // Seconds divider.
    logic blink;                 // Toggles every second.
    logic [8:0] secs;            // Seconds spent in the phase.
    logic [8:0] hold_l;          // Seconds the left magnet is held.
    logic [8:0] hold_r;          // Seconds the right magnet is held.
    logic [7:0] baseline;        // Reading when span started.
    logic signed [8:0] offset;   // Calibration offset on the raw reading.
    logic [7:0] win_start;       // Reading at start of a stability window.
    logic [1:0] retries;         // Extra stability windows used.
    logic [1:0] msg_idx;         // Step inside a message sequence.
    logic [2:0] faults;          // Latched range, stability, clearing faults.
    logic [3:0] fault_msg;       // Name of the fault being reported.
    logic o2_variant;            // Oxygen deficiency sensor.
    logic [7:0] span_level;      // Programmed span gas level.
    logic [15:0] loop_ua;        // Current loop level.
    logic [15:0] status;         // Serial status word.
    logic [3:0] disp_msg;        // Display message code.
    logic [7:0] disp_val;        // Display value.
    logic disp_flash;            // Display value flashes.
    logic [31:0] rdata;          // APB read data.
  } seq_regs_type;

  seq_regs_type r_q;
  seq_regs_type r_d;

  // Raw reading corrected by the offset and clamped to full scale.
  function automatic logic [7:0] apply_offset(input logic [7:0] raw,
                                              input logic signed [8:0] off);
    logic signed [9:0] sum;
    sum = $signed({2'b00, raw}) + 10'(off);
    if (sum < 0)
    begin
      return 8'h00;
    end
    else if (sum > $signed({2'b00, FULL_SCALE_PCT}))
    begin
      return FULL_SCALE_PCT;
    end
    return sum[7:0];
  endfunction

  // Unmapped addresses answer with an error.
  logic unmapped;
  assign unmapped = (paddr != ADDR_CTRL) && (paddr != ADDR_STATUS) &&
                    (paddr != ADDR_LOOP) && (paddr != ADDR_DISPLAY);

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;

  // All next-state and output logic except pready and pslverr.
  always_comb
  begin
    logic tick;
    logic left_on;
    logic right_on;
    logic [7:0] adj;
    logic [7:0] drift;
    logic [8:0] need;
    seq_state_type nxt;
    tick = 1'b0;
    left_on = 1'b0;
    right_on = 1'b0;
    adj = 8'h00;
    drift = 8'h00;
    need = 9'h000;
    nxt = r_q.state;
    r_d = r_q;

    // Magnet pins pass two flops before use.
    r_d.sync_l = {r_q.sync_l[0], left_magnet_switch};
    r_d.sync_r = {r_q.sync_r[0], right_magnet_switch};
    left_on = r_q.sync_l[1];
    right_on = r_q.sync_r[1];

    tick = (r_q.div == 28'(TICK_CYCLES - 1));
    r_d.div = tick ? 28'h0000000 : r_q.div + 28'h0000001;
    if (tick)
    begin
      r_d.blink = ~r_q.blink;
      r_d.secs = r_q.secs + 9'h001;
    end

    // Hold counters restart whenever the magnet leaves.
    r_d.hold_l = !left_on ? 9'h000 : (tick ? r_q.hold_l + 9'h001 : r_q.hold_l);
    r_d.hold_r = !right_on ? 9'h000 : (tick ? r_q.hold_r + 9'h001 : r_q.hold_r);

    adj = apply_offset(sensor_reading, r_q.offset);
    drift = (adj > r_q.win_start) ? adj - r_q.win_start : r_q.win_start - adj;
    need = {1'b0, r_q.baseline} + 9'(r_q.span_level >> 1);

    // Sequencer.
    case (r_q.state)
      ST_NORMAL:
      begin
        // menu entry on a full left hold.
        if (r_q.hold_l >= MENU_HOLD_S)
        begin
          nxt = ST_MENU;
          r_d.hold_r = 9'h000;
        end
      end
      ST_MENU:
      begin
        // right hold starts span, else time out.
        if (r_q.hold_r >= MENU_HOLD_S)
        begin
          nxt = ST_APPLY;
          r_d.baseline = adj;
        end
        else if (r_q.secs >= MENU_TIMEOUT_S)
        begin
          nxt = ST_NORMAL;
        end
      end
      ST_APPLY:
      begin
        // enough change moves on, timeout gives range fault.
        if ({1'b0, adj} >= need && adj > r_q.baseline)
        begin
          nxt = ST_ADJUST;
        end
        else if (r_q.secs >= RANGE_TIMEOUT_S)
        begin
          nxt = ST_FAULT_RPT;
          r_d.faults[0] = 1'b1;
          r_d.fault_msg = MSG_RANGE_FAULT;
        end
      end
      ST_ADJUST:
      begin
        // one percent step per second toward the span level.
        if (tick && adj < r_q.span_level)
        begin
          r_d.offset = r_q.offset + 9'sh001;
        end
        else if (tick && adj > r_q.span_level)
        begin
          r_d.offset = r_q.offset - 9'sh001;
        end
        if (r_q.secs >= ADJUST_S)
        begin
          nxt = ST_STABLE;
          r_d.win_start = adj;
          r_d.retries = 2'h0;
        end
      end
      ST_STABLE:
      begin
        if (r_q.secs >= STAB_S)
        begin
          if (drift <= STAB_TOL_PCT)
          begin
            nxt = ST_REPORT;
            r_d.msg_idx = 2'h0;
          end
          // out of extra windows, stability fault.
          else if (r_q.retries == MAX_EXTRA_CHECKS)
          begin
            nxt = ST_FAULT_RPT;
            r_d.faults[1] = 1'b1;
            r_d.fault_msg = MSG_STAB_FAULT;
          end
          // readjust to the span level and check again.
          else
          begin
            r_d.retries = r_q.retries + 2'h1;
            r_d.offset = $signed({1'b0, r_q.span_level}) - $signed({1'b0, sensor_reading});
            r_d.win_start = r_q.span_level;
            r_d.secs = 9'h000;
          end
        end
      end
      ST_REPORT:
      begin
        if (r_q.secs >= MSG_S)
        begin
          r_d.secs = 9'h000;
          r_d.msg_idx = r_q.msg_idx + 2'h1;
          if (r_q.msg_idx == REPORT_LAST)
          begin
            nxt = r_q.o2_variant ? ST_NORMAL : ST_CLEAR;
            if (r_q.o2_variant)
            begin
              r_d.faults = 3'h0;
            end
          end
        end
      end
      ST_CLEAR:
      begin
        if (adj < CLEAR_LIMIT_PCT)
        begin
          nxt = ST_DONE;
        end
        // too slow to clear, clearing fault.
        else if (r_q.secs >= CLEAR_TIMEOUT_S)
        begin
          nxt = ST_FAULT_RPT;
          r_d.faults[2] = 1'b1;
          r_d.fault_msg = MSG_CLEAR_FAULT;
        end
      end
      ST_DONE:
      begin
        // a completed span clears the faults here; an oxygen span clears them at the end of the report.
        if (r_q.secs >= MSG_S)
        begin
          nxt = ST_NORMAL;
          r_d.faults = 3'h0;
        end
      end
      ST_FAULT_RPT:
      begin
        if (r_q.secs >= MSG_S)
        begin
          r_d.secs = 9'h000;
          r_d.msg_idx = r_q.msg_idx + 2'h1;
          if (r_q.msg_idx == FAULT_RPT_LAST)
          begin
            nxt = ST_NORMAL;
          end
        end
      end
      default:
      begin
        nxt = ST_NORMAL;
      end
    endcase

    // every phase timer restarts on entry.
    if (nxt != r_q.state)
    begin
      r_d.secs = 9'h000;
      r_d.msg_idx = 2'h0;
      r_d.hold_l = 9'h000;
    end
    r_d.state = nxt;

    // calibration forces 2 mA before any fault level.
    if (nxt != ST_NORMAL)
    begin
      r_d.loop_ua = LOOP_CAL_UA;
    end
    // latched fault drops the loop to 0 mA.
    else if (r_d.faults != 3'h0)
    begin
      r_d.loop_ua = LOOP_FAULT_UA;
    end
    // linear loop across the full scale.
    else
    begin
      r_d.loop_ua = LOOP_MIN_UA + 16'(adj) * LOOP_UA_PER_PCT;
    end

    // calibration flag and fault bits on the serial word.
    r_d.status = 16'h0000;
    r_d.status[STS_CAL_BIT] = (nxt != ST_NORMAL);
    r_d.status[STS_RANGE_BIT] = r_d.faults[0];
    r_d.status[STS_STAB_BIT] = r_d.faults[1];
    r_d.status[STS_CLEAR_BIT] = r_d.faults[2];

    // Display content per phase.
    r_d.disp_msg = MSG_READING;
    r_d.disp_val = adj;
    r_d.disp_flash = 1'b0;
    case (nxt)
      ST_NORMAL:
      begin
        // fault indication alternates with the reading.
        if (r_d.faults != 3'h0 && r_d.blink)
        begin
          r_d.disp_msg = MSG_FAULT_DETECTED;
        end
      end
      ST_MENU:
      begin
        r_d.disp_msg = MSG_CAL_MENU;
      end
      ST_APPLY:
      begin
        // prompt with level, as-found once rising.
        r_d.disp_msg = (adj > r_q.baseline) ? MSG_AS_FOUND : MSG_APPLY_GAS;
        r_d.disp_val = (adj > r_q.baseline) ? adj : r_q.span_level;
        r_d.disp_flash = (adj > r_q.baseline);
      end
      ST_ADJUST, ST_STABLE:
      begin
        r_d.disp_msg = MSG_ADJUSTING;
      end
      ST_REPORT:
      begin
        r_d.disp_msg = (r_d.msg_idx == 2'h0) ? MSG_SPAN_OK :
                       (r_d.msg_idx == 2'h1) ? MSG_LIFE : MSG_REMOVE_GAS;
        r_d.disp_val = sensor_life_pct;
      end
      ST_DONE:
      begin
        r_d.disp_msg = MSG_SPAN_COMPLETE;
      end
      ST_FAULT_RPT:
      begin
        r_d.disp_msg = r_d.fault_msg;
      end
      default:
      begin
        r_d.disp_msg = MSG_READING;
      end
    endcase

    // APB write of the control word in the access phase.
    if (psel && penable && pwrite && paddr == ADDR_CTRL)
    begin
      r_d.o2_variant = pwdata[CTRL_O2_BIT];
      r_d.span_level = pwdata[CTRL_SPAN_LSB +: 8];
    end
    // APB read data captured in the setup phase.
    if (psel && !penable)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          r_d.rdata = {16'h0000, r_q.span_level, 7'h00, r_q.o2_variant};
        end
        ADDR_STATUS:
        begin
          r_d.rdata = {7'h00, r_q.state, r_q.status};
        end
        ADDR_LOOP:
        begin
          r_d.rdata = {16'h0000, r_q.loop_ua};
        end
        ADDR_DISPLAY:
        begin
          r_d.rdata = {19'h00000, r_q.disp_flash, r_q.disp_msg, r_q.disp_val};
        end
        default:
        begin
          r_d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q <= '0;
      r_q.state <= ST_NORMAL;
      r_q.span_level <= SPAN_LEVEL_RST;
      r_q.loop_ua <= LOOP_MIN_UA;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops.
  assign prdata = r_q.rdata;
  assign loop_current_ua = r_q.loop_ua;
  assign serial_status = r_q.status;
  assign display_msg = r_q.disp_msg;
  assign display_value = r_q.disp_val;
  assign display_flash = r_q.disp_flash;

  // Checks on the sequencer.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cal_loop_level: assert property (
    r_q.state != ST_NORMAL |-> loop_current_ua == LOOP_CAL_UA)
    else $error("Loop not at 2 mA during calibration.");
  a_cal_status_bit: assert property (
    serial_status[STS_CAL_BIT] == (r_q.state != ST_NORMAL))
    else $error("Calibration status bit wrong.");
  a_fault_zero_loop: assert property (
    (r_q.state == ST_NORMAL && r_q.faults != 3'h0) |-> loop_current_ua == LOOP_FAULT_UA)
    else $error("Loop not at 0 mA under a fault.");
  a_fault_stays_latched: assert property (
    (|(~r_q.faults & $past(r_q.faults))) |-> $past(r_q.state) inside {ST_DONE, ST_REPORT})
    else $error("Fault cleared without a completed span.");
  a_phase_timer_restart: assert property (
    $changed(r_q.state) |-> r_q.secs == 9'h000)
    else $error("Phase timer not restarted on entry.");
  a_menu_entry_hold: assert property (
    ($past(r_q.state) == ST_NORMAL && r_q.state == ST_MENU) |-> $past(r_q.hold_l) >= MENU_HOLD_S)
    else $error("Menu entered without a full hold.");
  a_menu_time_bound: assert property (
    r_q.state == ST_MENU |-> r_q.secs <= MENU_TIMEOUT_S)
    else $error("Menu outlived its timeout.");
  a_range_time_bound: assert property (
    r_q.state == ST_APPLY |-> r_q.secs <= RANGE_TIMEOUT_S)
    else $error("Signal change wait outlived its timeout.");
  a_stab_retry_limit: assert property (
    r_q.state == ST_STABLE |-> r_q.retries <= MAX_EXTRA_CHECKS)
    else $error("Too many stability windows.");
  a_clear_time_bound: assert property (
    r_q.state == ST_CLEAR |-> r_q.secs <= CLEAR_TIMEOUT_S)
    else $error("Clearing outlived its timeout.");
  a_ctrl_write_takes: assert property (
    (psel && penable && pwrite && paddr == ADDR_CTRL) |=> r_q.o2_variant == $past(pwdata[0]))
    else $error("Control write not taken.");

  c_span_started: cover property (r_q.state == ST_MENU ##1 r_q.state == ST_APPLY);
  c_span_completed: cover property (r_q.state == ST_DONE ##1 r_q.state == ST_NORMAL);
  c_fault_reported: cover property (r_q.state == ST_FAULT_RPT ##1 r_q.state == ST_NORMAL);

endmodule // span_calibration_sequencer
`default_nettype wire

// *** test/sensor_side_model.sv ***
// Purpose: Operator magnet switches and gas sensor signal facing the sequencer.
// Assumes: Bench commands change right after a rising pclk edge.
// Notes: Wobble makes the reading drift so every stability window fails; a rising
// reading climbs in steps so the as-found phase is visible before the change completes.
`timescale 1ns/1ps
`default_nettype none
module sensor_side_model
(
  input wire logic pclk,
  input wire logic hold_left,
  input wire logic hold_right,
  input wire logic wobble,
  input wire logic [7:0] gas_level,
  output logic left_magnet_switch = 1'b0,
  output logic right_magnet_switch = 1'b0,
  output logic [7:0] sensor_reading = 8'h00
);
  // Free drift counter; its upper bits step the reading once every 8 clocks.
  logic [6:0] drift_q = 7'h00;
  // Level the sensor heads for: the applied gas, plus the drift under wobble.
  logic [7:0] target;

  assign target = wobble ? gas_level + {4'h0, drift_q[6:3]} : gas_level;

  // Magnets follow the commands; a rising reading climbs four percent a clock,
  // as a real cell responds gradually, while a falling one drops at once.
  // gas equals span
  always @(posedge pclk)
  begin
    drift_q <= drift_q + 7'h01;
    left_magnet_switch <= hold_left;
    right_magnet_switch <= hold_right;
    if (target > sensor_reading + 8'h04)
    begin
      sensor_reading <= sensor_reading + 8'h04;
    end
    else
    begin
      sensor_reading <= target;
    end
  end
endmodule // sensor_side_model
`default_nettype wire

// *** test/span_calibration_sequencer_tb.sv ***
// Purpose: Self-checking bench for the span calibration sequencer.
// Assumes: One seconds tick every 20 clocks; registers reached over APB.
// Notes: Wait windows allow one tick of phase slack around each count.
`timescale 1ns/1ps
`default_nettype none
module span_calibration_sequencer_tb
  import span_cal_pkg::*;
;
  localparam int TICK = 20;
  localparam logic [7:0] LVL = 8'h28;
  localparam logic [7:0] LIFE = 8'h57;
  // Bench-driven inputs start defined at time zero.
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic hold_l = 1'b0, hold_r = 1'b0, wob = 1'b0;
  logic [7:0] paddr = 8'h00, gas = 8'h00, reading, value, vcap;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, left_sw, right_sw, flash, fcap, slverr;
  logic [15:0] loop_ua, status, faults = 16'h0000;
  logic [3:0] msg;
  int err_total = 0, comparisons = 0;

  span_calibration_sequencer #(.TICK_CYCLES(TICK)) uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .left_magnet_switch(left_sw), .right_magnet_switch(right_sw),
    .sensor_reading(reading), .sensor_life_pct(LIFE), .loop_current_ua(loop_ua),
    .serial_status(status), .display_msg(msg), .display_value(value), .display_flash(flash)
  );

  sensor_side_model partner
  (
    .pclk(pclk), .hold_left(hold_l), .hold_right(hold_r), .wobble(wob), .gas_level(gas),
    .left_magnet_switch(left_sw), .right_magnet_switch(right_sw), .sensor_reading(reading)
  );

  // Clock of 5 ns period.
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Counts: %0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      $display("ERROR %0t %s: got %h, expected %h", $time, what, got, exp);
      err_total++;
    end
  endtask

  // Waits for a display message and checks the wait against a cycle window.
  task automatic wait_msg(input logic [3:0] code, input int lo, input int hi);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (msg !== code && n <= hi);
    vcap = value;
    fcap = flash;
    comparisons++;
    if (n < lo || n > hi)
    begin
      $display("ERROR %0t message %h after %0d cycles", $time, code, n);
      err_total++;
    end
    @(posedge pclk);
  endtask

  // Checks loop current and serial status where they are settled.
  task automatic check_pins(input logic [15:0] lp, input logic [15:0] st);
    @(negedge pclk);
    check(32'(loop_ua), 32'(lp), "loop current");
    check(32'(status), 32'(st), "serial status");
    @(posedge pclk);
  endtask

  // One APB transfer; holds the request until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends once pready is seen high; if it never rises, only the watchdog ends it.
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Holds the left magnet until the calibration menu shows.
  task automatic enter_menu();
    hold_l <= 1'b1;
    wait_msg(MSG_CAL_MENU, 42, 70);
    hold_l <= 1'b0;
  endtask

  // Opens the menu and starts a span with the right magnet.
  task automatic start_span();
    enter_menu();
    hold_r <= 1'b1;
    wait_msg(MSG_APPLY_GAS, 42, 70);
    hold_r <= 1'b0;
    check(32'(vcap), 32'(LVL), "gas prompt level");
    check_pins(16'h07D0, 16'h4000 | faults);
  endtask

  // Applies span gas and follows the sequence up to the remove-gas prompt.
  task automatic run_to_remove();
    gas <= LVL;
    wait_msg(MSG_AS_FOUND, 1, 30);
    check(32'(fcap), 32'h1, "as-found flash");
    wait_msg(MSG_SPAN_OK, 1770, 1840);
    wait_msg(MSG_LIFE, 30, 50);
    check(32'(vcap), 32'(LIFE), "life value");
    wait_msg(MSG_REMOVE_GAS, 30, 50);
  endtask

  // Waits out the fault report and checks the faulted normal outputs.
  task automatic fault_normal();
    wait_msg(MSG_FAULT_DETECTED, 60, 125);
    check_pins(16'h0000, faults);
    wait_msg(MSG_READING, 1, 25);
  endtask

  // Test sequence.
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_3200, "control reset");
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h0001_0000, "status reset");
    apb(1'b1, ADDR_LOOP, 32'h0000_FFFF);
    apb(1'b0, ADDR_LOOP, 32'h0);
    check(rd, 32'h0000_0FA0, "loop read only");
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], slverr}, 32'h1, "unmapped read");
    apb(1'b1, ADDR_CTRL, 32'h0000_2800);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_2800, "control write");
    $display("test registers finished");
    enter_menu();
    check_pins(16'h07D0, 16'h4000);
    wait_msg(MSG_READING, 75, 105);
    check_pins(16'h0FA0, 16'h0000);
    $display("test menu timeout finished");
    start_span();
    wait_msg(MSG_RANGE_FAULT, 2970, 3010);
    faults = 16'h0002;
    fault_normal();
    $display("test range fault finished");
    start_span();
    run_to_remove();
    wait_msg(MSG_CLEAR_FAULT, 6010, 6080);
    faults = 16'h000A;
    fault_normal();
    gas <= 8'h00;
    $display("test clearing fault finished");
    start_span();
    run_to_remove();
    gas <= 8'h00;
    wait_msg(MSG_SPAN_COMPLETE, 30, 50);
    wait_msg(MSG_READING, 30, 50);
    faults = 16'h0000;
    check_pins(16'h0FA0, faults);
    $display("test span success finished");
    apb(1'b1, ADDR_CTRL, 32'h0000_2801);
    start_span();
    run_to_remove();
    wait_msg(MSG_READING, 30, 50);
    check_pins(16'h28A0, 16'h0000);
    gas <= 8'h00;
    $display("test oxygen span finished");
    start_span();
    wob <= 1'b1;
    gas <= LVL;
    wait_msg(MSG_AS_FOUND, 1, 30);
    wait_msg(MSG_STAB_FAULT, 3570, 3650);
    faults = 16'h0004;
    fault_normal();
    $display("test stability fault finished");
    end_sim();
  end

  // Watchdog cuts a hang short well beyond the expected run length.
  initial
  begin
    #200000;
    $display("ERROR %0t watchdog expired", $time);
    err_total++;
    end_sim();
  end
endmodule // span_calibration_sequencer_tb
`default_nettype wire
